// >>> clk_fanout_pkg.sv
// Shared constants and helpers for the clock fan-out control block and its serial host
// How it works
// (R1) Halt or sleep input stops all outputs
// (R2) Host releases both serial lines during sleep
// (R3) Two enable pins gate output pairs 0, 3
// (R4) Polarity pin high inverts enables, halt, sleep
// (R5) Mode pin picks PLL or bypass fan-out
// (R6) Bandwidth pin picks PLL loop bandwidth
// (R7) Halt input active low, requests clock stop
// (R8) Sleep input active low, requests power-down
// (R9) Serial port is slave only, indexed block
// (R10) Slave address 1101110 plus read/write bit
// (R11) Start, address, offset, count, N bytes, stop
// (R12) Host never sends write count of zero
// (R13) Bit 0: rate, 0 halves, resets 1
// (R14) Bit 1: path, 1 PLL, resets 1
// (R15) Bit 2: bandwidth, 1 low, resets 1
// (R16) Bits 6, 7: stopped outputs float when set
// (R17) Reserved bits 3-5 ignore writes, read zero
// (R18) Index advances by one per data byte
package clk_fanout_pkg;
    localparam logic [6:0] SMB_ADDR       = 7'h6e;
    localparam logic [7:0] REG_OUTPUT_MODE = 8'h00;
    localparam logic [7:0] MODE_RESET     = 8'h07;
    localparam logic [7:0] MODE_WMASK     = 8'hc7;
    localparam logic [7:0] NO_DATA        = 8'h00;
    localparam int         F_RATE         = 0;
    localparam int         F_PLL          = 1;
    localparam int         F_BW           = 2;
    localparam int         F_HALT_FLOAT   = 6;
    localparam int         F_SLEEP_FLOAT  = 7;
    localparam logic [3:0] BIT_LAST       = 4'h8;
    localparam logic [3:0] BIT_ACK        = 4'h9;
    localparam logic [1:0] STAGE_DATA     = 2'h3;
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         SMB_BIT_NS     = 10000;
    localparam int         QUARTER_CYC    = SMB_BIT_NS / (4 * CLK_PERIOD_NS);
    localparam logic [8:0] QUARTER_LAST   = 9'(QUARTER_CYC - 1);

    // Unmapped indexes read as zero; reserved bits never leave the register
    function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] mode);
        return (idx == REG_OUTPUT_MODE) ? (mode & MODE_WMASK) : NO_DATA;
    endfunction
endpackage

// >>> smbus_link_if.sv
// Two-wire serial link joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface smbus_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wired-and with pull-ups
    assign scl = host_scl_oe ? host_scl_o : 1'b1;
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// >>> input_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second; resets high as idle pins sit high
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '1;
            sync_o <= '1;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // input_sync
`default_nettype wire

// >>> fanout_ctrl_dev.sv
// Device end: serial slave, output mode register and output stop control
`timescale 1ns/1ps
`default_nettype none
module fanout_ctrl_dev
    import clk_fanout_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    smbus_link_if.dev       link,
    input  wire logic       pair0_enable_i,
    input  wire logic       pair3_enable_i,
    input  wire logic       control_polarity_flip_i,
    input  wire logic       clock_halt_n_i,
    input  wire logic       sleep_request_n_i,
    input  wire logic       pll_mode_i,
    input  wire logic       loop_bandwidth_select_i,
    output logic      [3:0] pair_run_o,
    output logic      [3:0] pair_float_o,
    output logic            rate_normal_o,
    output logic            pll_path_o,
    output logic            low_bandwidth_o,
    output logic            powered_down_o,
    output logic      [7:0] mode_byte_o
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_OFFS, S_CNT, S_WR, S_RD, S_WAIT} slave_e;

    logic [8:0] pins_s;
    logic       en0_s, en3_s, flip_n_s, halt_n_s, sleep_n_s, pllpin_s, bwpin_s, scl_s, sda_s;
    logic       scl_d1_q, sda_d1_q;
    slave_e     state_q, state_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] index_q, index_d;
    logic [7:0] remain_q, remain_d;
    logic [7:0] mode_q, mode_d;
    logic       rw_q, rw_d;
    logic       nacked_q, nacked_d;
    logic       pull_q, pull_d;

    input_sync #(.W(9)) u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i ({pair0_enable_i, pair3_enable_i, ~control_polarity_flip_i, clock_halt_n_i,
                   sleep_request_n_i, pll_mode_i, loop_bandwidth_select_i, link.scl, link.sda}),
        .sync_o  (pins_s)
    );
    assign {en0_s, en3_s, flip_n_s, halt_n_s, sleep_n_s, pllpin_s, bwpin_s, scl_s, sda_s} = pins_s;
    // Flip enters inverted so the idle-high sync reset cannot fake a halt or sleep
    wire flip_s = ~flip_n_s;                                       // R4

    // Pin polarity: flip inverts the enables and both active-low requests
    wire en0_act   = flip_s ? ~en0_s : en0_s;                      // R3 R4
    wire en3_act   = flip_s ? ~en3_s : en3_s;                      // R3 R4
    wire halt_act  = flip_s ? halt_n_s : ~halt_n_s;                // R7 R4
    wire sleep_act = flip_s ? sleep_n_s : ~sleep_n_s;              // R8 R4
    wire [3:0] pair_en = {en3_act, 1'b1, 1'b1, en0_act};           // R3

    // Stop and float decisions; a disabled pair is held driven low
    wire       stopped = halt_act | sleep_act;                     // R1
    wire       floats  = (halt_act & mode_q[F_HALT_FLOAT])
                       | (sleep_act & mode_q[F_SLEEP_FLOAT]);      // R16
    wire [3:0] run_d   = stopped ? 4'h0 : pair_en;                 // R1
    wire [3:0] float_d = stopped ? {4{floats}} : 4'h0;             // R1 R16

    // Bus conditions seen on the synchronised lines
    wire scl_rise = scl_s & ~scl_d1_q;
    wire scl_fall = ~scl_s & scl_d1_q;
    wire start_c  = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
    wire stop_c   = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
    wire active   = (state_q != S_IDLE) && (state_q != S_WAIT);
    wire [7:0] rd_byte = reg_read(index_q, mode_q);                // R17

    // Slave sequencer: bits shift on rise, the line changes only after a fall
    always_comb begin
        logic load;
        load     = 1'b0;
        state_d  = state_q;
        bitcnt_d = bitcnt_q;
        shift_d  = shift_q;
        tx_d     = tx_q;
        index_d  = index_q;
        remain_d = remain_q;
        mode_d   = mode_q;
        rw_d     = rw_q;
        nacked_d = nacked_q;
        pull_d   = pull_q;
        if (sleep_act) begin
            // Host has released the lines, so ignore whatever they do
            state_d = S_IDLE;
            pull_d  = 1'b0;
        end else if (start_c) begin
            state_d  = S_ADDR;                                     // R11
            bitcnt_d = 4'h0;
            pull_d   = 1'b0;
        end else if (stop_c) begin
            state_d = S_IDLE;                                      // R11
            pull_d  = 1'b0;
        end else if (active && scl_rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
            if (bitcnt_q < BIT_LAST) begin
                shift_d = {shift_q[6:0], sda_s};
            end else if (state_q == S_RD && sda_s) begin
                nacked_d = 1'b1;
            end
        end else if (active && scl_fall) begin
            if (bitcnt_q == BIT_LAST) begin
                pull_d = 1'b0;
                case (state_q)
                    S_ADDR: begin
                        if (shift_q[7:1] == SMB_ADDR) begin           // R10
                            pull_d = 1'b1;
                            rw_d   = shift_q[0];                      // R10
                        end else begin
                            state_d = S_WAIT;
                        end
                    end
                    S_OFFS: begin
                        index_d = shift_q;                         // R18
                        pull_d  = 1'b1;
                    end
                    S_CNT: begin
                        remain_d = shift_q;                        // R11
                        pull_d   = 1'b1;
                    end
                    S_WR: begin
                        if (remain_q != 8'h00) begin
                            if (index_q == REG_OUTPUT_MODE) begin
                                mode_d = shift_q & MODE_WMASK;     // R13 R14 R15 R16 R17
                            end
                            index_d  = index_q + 8'h01;            // R18
                            remain_d = remain_q - 8'h01;
                            pull_d   = 1'b1;
                        end
                    end
                    default: pull_d = 1'b0;
                endcase
            end else if (bitcnt_q == BIT_ACK) begin
                bitcnt_d = 4'h0;
                pull_d   = 1'b0;
                case (state_q)
                    S_ADDR: state_d = S_OFFS;                      // R11
                    S_OFFS: state_d = S_CNT;                       // R11
                    S_CNT: begin
                        // A zero count ends the transfer; hosts never send one for writes
                        if (remain_q == 8'h00) begin
                            state_d = S_WAIT;                      // R12
                        end else if (rw_q) begin
                            load = 1'b1;
                        end else begin
                            state_d = S_WR;
                        end
                    end
                    S_WR: state_d = (remain_q == 8'h00) ? S_WAIT : S_WR;
                    S_RD: begin
                        if (nacked_q || remain_q == 8'h00) begin
                            state_d = S_WAIT;
                        end else begin
                            load = 1'b1;
                        end
                    end
                    default: state_d = S_WAIT;
                endcase
            end else if (state_q == S_RD) begin
                pull_d = ~tx_q[3'(3'h7 - bitcnt_q[2:0])];
            end
            if (load) begin
                state_d  = S_RD;
                tx_d     = rd_byte;
                index_d  = index_q + 8'h01;                        // R18
                remain_d = remain_q - 8'h01;
                nacked_d = 1'b0;
                pull_d   = ~rd_byte[7];
            end
        end
    end

    // Sequencer and mode register; the register powers up to its documented value
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q  <= S_IDLE;
            bitcnt_q <= 4'h0;
            shift_q  <= 8'h00;
            tx_q     <= 8'h00;
            index_q  <= 8'h00;
            remain_q <= 8'h00;
            mode_q   <= MODE_RESET;                                // R13 R14 R15 R16
            rw_q     <= 1'b0;
            nacked_q <= 1'b0;
            pull_q   <= 1'b0;
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            state_q  <= state_d;
            bitcnt_q <= bitcnt_d;
            shift_q  <= shift_d;
            tx_q     <= tx_d;
            index_q  <= index_d;
            remain_q <= remain_d;
            mode_q   <= mode_d;
            rw_q     <= rw_d;
            nacked_q <= nacked_d;
            pull_q   <= pull_d;
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
        end
    end

    // Registered outputs toward the analog clock path
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pair_run_o      <= 4'h0;
            pair_float_o    <= 4'h0;
            rate_normal_o   <= 1'b1;
            pll_path_o      <= 1'b1;
            low_bandwidth_o <= 1'b1;
            powered_down_o  <= 1'b0;
            mode_byte_o     <= MODE_RESET;
        end else begin
            pair_run_o      <= run_d;                              // R1
            pair_float_o    <= float_d;                            // R16
            rate_normal_o   <= mode_q[F_RATE];                     // R13
            pll_path_o      <= mode_q[F_PLL] & pllpin_s;           // R5 R14
            low_bandwidth_o <= mode_q[F_BW] & bwpin_s;             // R6 R15
            powered_down_o  <= sleep_act;                          // R8
            mode_byte_o     <= mode_q & MODE_WMASK;
        end
    end

    // Slave only ever pulls data low; it never drives the clock
    assign link.dev_sda_o  = 1'b0;                                 // R9
    assign link.dev_sda_oe = pull_q;
endmodule // fanout_ctrl_dev
`default_nettype wire

// >>> smbus_host.sv
// Host end: issues indexed block reads and writes over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module smbus_host
    import clk_fanout_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    smbus_link_if.host      link,
    input  wire logic       sleep_i,
    input  wire logic       cmd_valid_i,
    output logic            cmd_ready_o,
    input  wire logic       cmd_read_i,
    input  wire logic [7:0] cmd_offset_i,
    input  wire logic [7:0] cmd_count_i,
    input  wire logic [7:0] wr_data_i,
    output logic            wr_take_o,
    output logic      [7:0] rd_data_o,
    output logic            rd_valid_o,
    output logic            done_o,
    output logic            nack_o
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_e;

    host_e      state_q;
    logic [8:0] qcnt_q;
    logic [1:0] phase_q, stage_q;
    logic [3:0] bit_q;
    logic [7:0] txb_q, rx_q, off_q, rem_q, cnt_q;
    logic       rd_q, ackbit_q, scl_pull_q, sda_pull_q, sda_s;

    input_sync #(.W(1)) u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i (link.sda),
        .sync_o  (sda_s)
    );

    wire tick      = (qcnt_q == QUARTER_LAST);
    wire reading   = rd_q && (stage_q == STAGE_DATA);
    wire byte_end  = (state_q == H_BIT) && tick && (phase_q == 2'h3) && (bit_q == BIT_LAST);
    wire [7:0] rem_next = rem_q - 8'h01;
    wire bit_val   = txb_q[3'(3'h7 - bit_q[2:0])];
    // Idle lines only; during sleep the host takes no command
    assign cmd_ready_o = (state_q == H_IDLE) && !sleep_i;           // R2

    // Byte sequencer; quarters of a bit are paced by a counter, no clock stretching
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= H_IDLE;
            qcnt_q <= 9'h000;
            phase_q <= 2'h0;
            stage_q <= 2'h0;
            bit_q <= 4'h0;
            {txb_q, rx_q, off_q, rem_q, cnt_q} <= '0;
            {rd_q, ackbit_q, scl_pull_q, sda_pull_q} <= '0;
            {wr_take_o, rd_valid_o, done_o, nack_o} <= '0;
            rd_data_o <= 8'h00;
        end else begin
            {wr_take_o, rd_valid_o, done_o} <= '0;
            qcnt_q <= (tick || state_q == H_IDLE) ? 9'h000 : qcnt_q + 9'h001;
            if (tick) begin
                phase_q <= phase_q + 2'h1;
            end
            if (sleep_i) begin
                state_q    <= H_IDLE;                              // R2
                scl_pull_q <= 1'b0;                                // R2
                sda_pull_q <= 1'b0;                                // R2
                phase_q    <= 2'h0;
            end else if (state_q == H_IDLE) begin
                phase_q <= 2'h0;
                if (cmd_valid_i) begin
                    state_q <= H_START;
                    nack_o  <= 1'b0;
                    rd_q    <= cmd_read_i;
                    off_q   <= cmd_offset_i;
                    txb_q   <= {SMB_ADDR, cmd_read_i};             // R10
                    cnt_q   <= (!cmd_read_i && cmd_count_i == 8'h00) ? 8'h01 : cmd_count_i; // R12
                    stage_q <= 2'h0;
                    bit_q   <= 4'h0;
                end
            end else if (state_q == H_START && tick) begin
                // Data falls while the clock is high, then the clock falls
                if (phase_q == 2'h0) sda_pull_q <= 1'b1;           // R11
                if (phase_q == 2'h1) begin
                    scl_pull_q <= 1'b1;
                    state_q    <= H_BIT;
                    phase_q    <= 2'h0;
                end
            end else if (state_q == H_BIT && tick) begin
                case (phase_q)
                    2'h0: begin
                        if (bit_q < BIT_LAST) sda_pull_q <= reading ? 1'b0 : ~bit_val;
                        else sda_pull_q <= reading && (rem_q != 8'h01);
                    end
                    2'h1: scl_pull_q <= 1'b0;
                    2'h2: begin
                        if (bit_q < BIT_LAST) rx_q <= {rx_q[6:0], sda_s};
                        else ackbit_q <= sda_s;
                    end
                    default: begin
                        scl_pull_q <= 1'b1;
                        bit_q      <= bit_q + 4'h1;
                    end
                endcase
            end else if (state_q == H_STOP && tick) begin
                // Clock rises first, then data rises while it is high
                if (phase_q == 2'h0) begin
                    sda_pull_q <= 1'b1;
                    scl_pull_q <= 1'b1;
                end
                if (phase_q == 2'h1) scl_pull_q <= 1'b0;
                if (phase_q == 2'h2) begin
                    sda_pull_q <= 1'b0;                            // R11
                    state_q    <= H_IDLE;
                    done_o     <= 1'b1;
                end
            end
            if (byte_end && !sleep_i) begin
                bit_q <= 4'h0;
                if (!reading && ackbit_q) begin
                    nack_o  <= 1'b1;
                    state_q <= H_STOP;
                end else begin
                    case (stage_q)
                        2'h0: txb_q <= off_q;                      // R11
                        2'h1: begin
                            txb_q <= cnt_q;
                            rem_q <= cnt_q;
                        end
                        2'h2: begin
                            txb_q     <= wr_data_i;
                            wr_take_o <= !rd_q && (rem_q != 8'h00);
                        end
                        default: begin
                            rem_q      <= rem_next;
                            rd_data_o  <= rx_q;
                            rd_valid_o <= rd_q;
                            txb_q      <= wr_data_i;
                            wr_take_o  <= !rd_q && (rem_next != 8'h00);
                        end
                    endcase
                    if (stage_q != STAGE_DATA) stage_q <= stage_q + 2'h1;
                    if ((stage_q == 2'h2 && rem_q == 8'h00) ||
                        (stage_q == STAGE_DATA && rem_next == 8'h00)) begin
                        state_q <= H_STOP;
                    end
                end
            end
        end
    end

    assign link.host_scl_o  = 1'b0;
    assign link.host_scl_oe = scl_pull_q;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = sda_pull_q;
endmodule // smbus_host
`default_nettype wire

// >>> fanout_asserts.sv
// Concurrent checks on the serial link and the output stop control
`timescale 1ns/1ps
`default_nettype none
module fanout_asserts (
    input wire logic       mclk_i,
    input wire logic       nrst_i,
    input wire logic       scl,
    input wire logic       host_scl_oe,
    input wire logic       host_sda_oe,
    input wire logic       dev_sda_oe,
    input wire logic       sleep_i,
    input wire logic       cmd_ready_o,
    input wire logic [3:0] pair_run_o,
    input wire logic [3:0] pair_float_o,
    input wire logic       powered_down_o,
    input wire logic       rate_normal_o,
    input wire logic [7:0] mode_byte_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Start is the only data pull made while the clock line is released
    sequence s_start;
        $rose(host_sda_oe) && !host_scl_oe;
    endsequence
    sequence s_clock_pulled;
        ##[200:300] host_scl_oe;
    endsequence
    property p_start_shape; s_start |-> s_clock_pulled; endproperty
    a_start_shape: assert property (p_start_shape) else $error("start shape bad");
    property p_release_sleep; $rose(sleep_i) |-> ##[0:8] (!host_scl_oe && !host_sda_oe); endproperty
    a_release_sleep: assert property (p_release_sleep) else $error("lines held in sleep");
    property p_no_cmd_sleep; sleep_i |-> !cmd_ready_o; endproperty
    a_no_cmd_sleep: assert property (p_no_cmd_sleep) else $error("ready in sleep");
    property p_reserved; mode_byte_o[5:3] == 3'h0; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_float_stop; (pair_float_o != 4'h0) |-> (pair_run_o == 4'h0); endproperty
    a_float_stop: assert property (p_float_stop) else $error("float while running");
    // Two cycles of sleep give the registered outputs time to follow
    property p_sleep_stop; powered_down_o [*2] |-> pair_run_o == 4'h0; endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("run in sleep");
    property p_sleep_float; (powered_down_o && mode_byte_o[7]) [*2] |-> pair_float_o == 4'hf;
    endproperty
    a_sleep_float: assert property (p_sleep_float) else $error("no float in sleep");
    property p_rate; $stable(mode_byte_o) |-> rate_normal_o == mode_byte_o[0]; endproperty
    a_rate: assert property (p_rate) else $error("rate bit mismatch");
    // Device answers only a few cycles into the clock low phase
    property p_ack_time; $rose(dev_sda_oe) |-> !scl && $past(scl, 8); endproperty
    a_ack_time: assert property (p_ack_time) else $error("device drive timing");
endmodule // fanout_asserts
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench: host end drives the device end over the shared link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clk_fanout_pkg::*;
    logic       mclk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       en0 = 1'b1, en3 = 1'b1, flip = 1'b0, halt_n = 1'b1, sleep_n = 1'b1;
    logic       pll_mode = 1'b1, bw_sel = 1'b1, sleep = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
    logic [7:0] cmd_count = 8'h00, wr_data = 8'h00, rd_data, mode_byte, rd_byte;
    logic [3:0] pair_run, pair_float;
    logic       rate_normal, pll_path, low_bw, powered_down, cmd_ready, wr_take, rd_valid, done, nack;
    int         num_errors = 0;
    int         n_compared = 0;
    int         cycles = 0;
    smbus_link_if smbus_link_if_inst ();
    fanout_ctrl_dev fanout_ctrl_dev_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .link(smbus_link_if_inst.dev), .pair0_enable_i(en0), .pair3_enable_i(en3),
        .control_polarity_flip_i(flip), .clock_halt_n_i(halt_n), .sleep_request_n_i(sleep_n),
        .pll_mode_i(pll_mode), .loop_bandwidth_select_i(bw_sel), .pair_run_o(pair_run),
        .pair_float_o(pair_float), .rate_normal_o(rate_normal), .pll_path_o(pll_path),
        .low_bandwidth_o(low_bw), .powered_down_o(powered_down), .mode_byte_o(mode_byte));
    smbus_host smbus_host_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .link(smbus_link_if_inst.host),
        .sleep_i(sleep), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
        .cmd_offset_i(REG_OUTPUT_MODE), .cmd_count_i(cmd_count), .wr_data_i(wr_data),
        .wr_take_o(wr_take), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .done_o(done),
        .nack_o(nack));
    fanout_asserts fanout_asserts_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .scl(smbus_link_if_inst.scl), .host_scl_oe(smbus_link_if_inst.host_scl_oe),
        .host_sda_oe(smbus_link_if_inst.host_sda_oe), .dev_sda_oe(smbus_link_if_inst.dev_sda_oe),
        .sleep_i(sleep), .cmd_ready_o(cmd_ready), .pair_run_o(pair_run),
        .pair_float_o(pair_float), .powered_down_o(powered_down), .rate_normal_o(rate_normal),
        .mode_byte_o(mode_byte));

    // Free-running 100 MHz clock
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    // Two transfers need about 84k cycles, so the ceiling leaves some slack
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Pins pass two synchroniser stages and a register before they show
    task automatic settle();
        repeat (6) @(negedge mclk_i);
    endtask

    // One indexed block transfer at offset zero; d1 is offered after the first take
    task automatic xfer(input logic rd, input logic [7:0] cnt, input logic [7:0] d0,
                        input logic [7:0] d1);
        cmd_read = rd;
        cmd_count = cnt;
        wr_data = d0;
        cmd_valid = 1'b1;
        @(negedge mclk_i);
        cmd_valid = 1'b0;
        for (int n = 0; n < 60000 && done !== 1'b1; n++) begin
            @(negedge mclk_i);
            if (wr_take === 1'b1) wr_data = d1;
            if (rd_valid === 1'b1) rd_byte = rd_data;
        end
        chk("done", done, 8'h01);
        chk("nack", nack, 8'h00);
    endtask

    task automatic t_reset_values();
        chk("mode", mode_byte, 8'h07);
        chk("rate", rate_normal, 8'h01);
        chk("pll", pll_path, 8'h01);
        chk("bw", low_bw, 8'h01);
        chk("run", pair_run, 8'h0f);
    endtask

    task automatic t_pins();
        en0 = 1'b0;
        settle();
        chk("run", pair_run, 8'h0e);
        en0 = 1'b1;
        en3 = 1'b0;
        settle();
        chk("run", pair_run, 8'h07);
        flip = 1'b1;
        halt_n = 1'b0;
        sleep_n = 1'b0;
        en0 = 1'b0;
        settle();
        chk("run", pair_run, 8'h0f);
        chk("sleep", powered_down, 8'h00);
        {flip, halt_n, sleep_n, en0, en3, pll_mode, bw_sel} = 7'h7c;
        settle();
        chk("pll", pll_path, 8'h00);
        chk("bw", low_bw, 8'h00);
        chk("run", pair_run, 8'h00);
        chk("float", pair_float, 8'h00);
        {flip, halt_n, pll_mode, bw_sel} = 4'h7;
        settle();
    endtask

    // Second byte lands on index 1, so it must not disturb the mode byte
    task automatic t_write_read();
        xfer(1'b0, 8'h02, 8'hf8, 8'h00);
        settle();
        chk("mode", mode_byte, 8'hc0);
        chk("rate", rate_normal, 8'h00);
        chk("pll", pll_path, 8'h00);
        chk("bw", low_bw, 8'h00);
        xfer(1'b1, 8'h01, 8'h00, 8'h00);
        chk("read", rd_byte, 8'hc0);
        halt_n = 1'b0;
        settle();
        chk("run", pair_run, 8'h00);
        chk("float", pair_float, 8'h0f);
        halt_n = 1'b1;
        settle();
    endtask

    task automatic t_sleep();
        sleep = 1'b1;
        sleep_n = 1'b0;
        settle();
        chk("sleep", powered_down, 8'h01);
        chk("run", pair_run, 8'h00);
        chk("float", pair_float, 8'h0f);
        chk("sda", smbus_link_if_inst.sda, 8'h01);
        chk("scl", smbus_link_if_inst.scl, 8'h01);
    endtask

    initial begin
        repeat (16) @(negedge mclk_i);
        nrst_i = 1'b1;
        settle();
        t_reset_values();
        t_pins();
        t_write_read();
        t_sleep();
        close_out();
    end
endmodule // tb_top
`default_nettype wire
